// file: rtl/counter_array_compare.sv
/*
 * Counter array: 16-bit counter, five compare modules (software timer,
 * toggle output, frequency output, 8- and 16-bit pulse modes) and the
 * watchdog built on module 4, reached as an APB slave.
 * Assumes the event and external clock pins are asynchronous to pclk,
 * while the timer overflow pulse and the idle level come from pclk logic.
 */
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Compare enabled with match sets event flag
// - Event flags are cleared only by software
// - Low byte write clears, high sets enable
// - Toggle mode inverts pin on 16-bit match
// - Frequency mode toggles, adds high to low
// - High byte zero means 256-clock half period
// - 8-bit pulse: high on match, low overflow
// - 8-bit pulse reloads low from high byte
// - Enable clear gives 0%, zero gives 100%
// - 16-bit pulse: high on match, low overflow
// - Watchdog compares reload byte with counter high
// - Watchdog active after reset, divide-by-12 timebase
// - Watchdog forces run, freezes counter and settings
// - Run bit writes stored but not obeyed, reads software value
// - Reload write loads counter high plus offset
// - Low overflow at reload match resets system
// - Writing module 4 flag forces reset
// - Lock keeps watchdog until reset; else disable
// - Enabled event flag raises shared interrupt
// - Mode register locked while watchdog enabled
module counter_array_compare (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Timebase sources and CPU state
	input  wire logic        timer0_overflow,
	input  wire logic        count_event_pin,
	input  wire logic        ext_clock_pin,
	input  wire logic        cpu_idle,
	// Outputs
	output logic      [4:0]  module_output_pin,
	output logic             array_irq,
	output logic             watchdog_reset
);

	typedef struct packed {
		logic [15:0]     count;
		logic [7:0]      snapshot;
		logic            run;
		logic            ovf_flag;
		logic [4:0]      event_flag;
		logic            idle_suspend;
		logic            wdt_enable;
		logic            wdt_lock;
		logic            ovf_irq_enable;
		logic [2:0]      timebase;
		logic [4:0][7:0] module_mode;
		logic [4:0][7:0] cmp_low;
		logic [4:0][7:0] cmp_high;
		logic [4:0]      pin;
		logic [3:0]      div12;
		logic [1:0]      div4;
		logic [2:0]      div8;
		logic [2:0]      event_sync;
		logic            event_level;
		logic [2:0]      ext_sync;
		logic            ext_level;
		logic [31:0]     rdata;
		logic            err;
		logic            irq;
		logic            wdt_reset;
	} state_s;

	state_s s;
	state_s next_s;

	function automatic logic [7:0] slot_addr(input logic [7:0] base,
	                                         input int idx);
		slot_addr = base + 8'(idx * 4);
	endfunction

	function automatic logic is_mapped(input logic [7:0] addr);
		logic hit;
		hit = (addr == counter_array_pkg::CONTROL_OFFSET) ||
		      (addr == counter_array_pkg::ARRAY_MODE_OFFSET) ||
		      (addr == counter_array_pkg::COUNT_LOW_OFFSET) ||
		      (addr == counter_array_pkg::COUNT_HIGH_OFFSET);
		for (int i = 0; i < counter_array_pkg::NUM_MODULES; i++) begin
			hit = hit ||
			      addr == slot_addr(counter_array_pkg::MODULE_MODE_BASE, i) ||
			      addr == slot_addr(counter_array_pkg::COMPARE_LOW_BASE, i) ||
			      addr == slot_addr(counter_array_pkg::COMPARE_HIGH_BASE, i);
		end
		is_mapped = hit;
	endfunction

	logic        wdt_active;
	logic        src_tick;
	logic        tick;
	logic        low_ovf;
	logic        full_ovf;
	logic [15:0] next_count;
	logic [4:0]  set_flags;
	logic        setup;
	logic        wr;
	logic        count_write;
	logic [7:0]  wb;
	logic [7:0]  mm;
	logic        m8;
	logic        m16;
	logic        pulse8;

	// The access phase always completes in its first cycle.
	assign pready  = penable;
	assign pslverr = penable & s.err;
	assign prdata  = s.rdata;
	assign module_output_pin = s.pin;
	assign array_irq         = s.irq;
	assign watchdog_reset    = s.wdt_reset;

	always_comb begin
		next_s = s;
		next_s.wdt_reset = 1'b0;
		wb = pwdata[7:0];
		setup = psel & ~penable;
		wr = psel & penable & pwrite & is_mapped(paddr);
		wdt_active = s.wdt_enable | s.wdt_lock;
		set_flags = 5'h00;
		count_write = 1'b0;
		mm = 8'h00;
		m8 = 1'b0;
		m16 = 1'b0;
		pulse8 = 1'b0;

		// Pin inputs: a level counts once the 2nd and 3rd stages agree.
		next_s.event_sync = {s.event_sync[1:0], count_event_pin};
		next_s.ext_sync   = {s.ext_sync[1:0], ext_clock_pin};
		if (s.event_sync[1] == s.event_sync[2]) begin
			next_s.event_level = s.event_sync[2];
		end
		if (s.ext_sync[1] == s.ext_sync[2]) begin
			next_s.ext_level = s.ext_sync[2];
		end

		// Prescalers: div12 and div4 run freely, div8 counts rising edges of the external clock.
		next_s.div12 = (s.div12 == counter_array_pkg::DIV12_LAST) ?
		               4'h0 : s.div12 + 4'h1;
		next_s.div4 = s.div4 + 2'h1;
		if (~s.ext_level & next_s.ext_level) begin
			next_s.div8 = s.div8 + 3'h1;
		end

		case (s.timebase)
			counter_array_pkg::TB_DIV12:
				src_tick = (s.div12 == counter_array_pkg::DIV12_LAST);
			counter_array_pkg::TB_DIV4:
				src_tick = (s.div4 == counter_array_pkg::DIV4_LAST);
			counter_array_pkg::TB_TIMER0:
				src_tick = timer0_overflow;
			counter_array_pkg::TB_EVENT:
				src_tick = s.event_level & ~next_s.event_level;
			counter_array_pkg::TB_SYSCLK:
				src_tick = 1'b1;
			counter_array_pkg::TB_EXT8:
				src_tick = ~s.ext_level & next_s.ext_level &
				           (s.div8 == counter_array_pkg::EXT8_LAST);
			default:
				src_tick = 1'b0;
		endcase

		// The watchdog keeps the counter running whatever the run bit says.
		tick = src_tick & (s.run | wdt_active) &
		       ~(s.idle_suspend & cpu_idle);
		next_count = s.count + 16'h0001;
		low_ovf  = tick & (s.count[7:0] == 8'hFF);
		full_ovf = tick & (s.count == 16'hFFFF);

		// Every compare, reload and watchdog check waits for the tick.
		if (tick) begin
			next_s.count = next_count;
			if (full_ovf) begin
				next_s.ovf_flag = 1'b1;
			end
			for (int i = 0; i < counter_array_pkg::NUM_MODULES; i++) begin
				mm  = s.module_mode[i];
				m16 = (next_count == {s.cmp_high[i], s.cmp_low[i]});
				m8  = (next_count[7:0] == s.cmp_low[i]);
				pulse8 = mm[counter_array_pkg::MM_PWM_BIT] &
				         ~mm[counter_array_pkg::MM_TOG_BIT] &
				         ~mm[counter_array_pkg::MM_WIDE_BIT];
				if (i == counter_array_pkg::WDT_MODULE && wdt_active) begin
					// Module 4 is the watchdog: no pin or flag activity.
				end else if (mm[counter_array_pkg::MM_PWM_BIT] &
				             ~mm[counter_array_pkg::MM_ECOM_BIT]) begin
					next_s.pin[i] = 1'b0;
				end else if (mm[counter_array_pkg::MM_ECOM_BIT]) begin
					if (mm[counter_array_pkg::MM_PWM_BIT] &
					    mm[counter_array_pkg::MM_TOG_BIT]) begin
						// Adding 0x00 wraps the low byte by 256 counts.
						if (m8) begin
							next_s.pin[i] = ~s.pin[i];
							next_s.cmp_low[i] = s.cmp_low[i] + s.cmp_high[i];
						end
					end else if (pulse8) begin
						// Overflow reload first, so a zero value stays high.
						if (low_ovf) begin
							next_s.cmp_low[i] = s.cmp_high[i];
							next_s.pin[i] = (s.cmp_high[i] == 8'h00);
						end else if (m8) begin
							next_s.pin[i] = 1'b1;
						end
					end else if (mm[counter_array_pkg::MM_PWM_BIT]) begin
						// A match at count zero wins over the overflow.
						if (m16) begin
							next_s.pin[i] = 1'b1;
						end else if (full_ovf) begin
							next_s.pin[i] = 1'b0;
						end
					end else if (mm[counter_array_pkg::MM_TOG_BIT] &
					             mm[counter_array_pkg::MM_MAT_BIT] & m16) begin
						next_s.pin[i] = ~s.pin[i];
					end
					if (mm[counter_array_pkg::MM_MAT_BIT]) begin
						set_flags[i] = (mm[counter_array_pkg::MM_PWM_BIT] &
						                ~mm[counter_array_pkg::MM_WIDE_BIT]) ?
						               m8 : m16;
					end
				end
			end
			if (wdt_active & low_ovf &
			    s.cmp_high[counter_array_pkg::WDT_MODULE] == s.count[15:8]) begin
				next_s.wdt_reset = 1'b1;
			end
		end

		// Register reads are prepared in the setup cycle.
		next_s.err = setup & ~is_mapped(paddr);
		if (setup) begin
			next_s.rdata = 32'h0000_0000;
			if (paddr == counter_array_pkg::CONTROL_OFFSET) begin
				next_s.rdata[7:0] = {s.ovf_flag, s.run, 1'b0, s.event_flag};
			end else if (paddr == counter_array_pkg::ARRAY_MODE_OFFSET) begin
				next_s.rdata[7:0] = {s.idle_suspend, s.wdt_enable, s.wdt_lock,
				                     1'b0, s.timebase, s.ovf_irq_enable};
			end else if (paddr == counter_array_pkg::COUNT_LOW_OFFSET) begin
				next_s.rdata[7:0] = s.count[7:0];
				if (~pwrite) begin
					next_s.snapshot = s.count[15:8];
				end
			end else if (paddr == counter_array_pkg::COUNT_HIGH_OFFSET) begin
				next_s.rdata[7:0] = s.snapshot;
			end
			for (int i = 0; i < counter_array_pkg::NUM_MODULES; i++) begin
				if (paddr == slot_addr(counter_array_pkg::MODULE_MODE_BASE, i)) begin
					next_s.rdata[7:0] = s.module_mode[i];
				end
				if (paddr == slot_addr(counter_array_pkg::COMPARE_LOW_BASE, i)) begin
					next_s.rdata[7:0] = s.cmp_low[i];
				end
				if (paddr == slot_addr(counter_array_pkg::COMPARE_HIGH_BASE, i)) begin
					next_s.rdata[7:0] = s.cmp_high[i];
				end
			end
		end

		// Writes take effect at the access edge; they beat the tick, except its flag sets.
		if (wr) begin
			if (paddr == counter_array_pkg::CONTROL_OFFSET) begin
				next_s.run = wb[counter_array_pkg::CTL_RUN_BIT];
				next_s.ovf_flag = wb[counter_array_pkg::CTL_OVF_BIT];
				next_s.event_flag = wb[4:0];
				if (wdt_active & wb[counter_array_pkg::WDT_MODULE]) begin
					next_s.wdt_reset = 1'b1;
				end
			end else if (paddr == counter_array_pkg::ARRAY_MODE_OFFSET) begin
				if (s.wdt_enable) begin
					// Only the enable bit is taken, and only when it turns the watchdog off.
					if (~wb[counter_array_pkg::AM_WATCHDOG_ENABLE_BIT]) begin
						next_s.wdt_enable = 1'b0;
					end
				end else begin
					next_s.wdt_enable = wb[counter_array_pkg::AM_WATCHDOG_ENABLE_BIT];
					next_s.wdt_lock = s.wdt_lock |
					                  wb[counter_array_pkg::AM_WATCHDOG_LOCK_BIT];
					next_s.ovf_irq_enable = wb[counter_array_pkg::AM_OVFIE_BIT];
					if (~wdt_active) begin
						next_s.idle_suspend = wb[counter_array_pkg::AM_IDLE_BIT];
						next_s.timebase =
						    wb[counter_array_pkg::AM_TB_LSB +: 3];
					end
				end
			end else if (~wdt_active &&
			             paddr == counter_array_pkg::COUNT_LOW_OFFSET) begin
				next_s.count[7:0] = wb;
				count_write = 1'b1;
			end else if (~wdt_active &&
			             paddr == counter_array_pkg::COUNT_HIGH_OFFSET) begin
				next_s.count[15:8] = wb;
				count_write = 1'b1;
			end
			for (int i = 0; i < counter_array_pkg::NUM_MODULES; i++) begin
				if (i == counter_array_pkg::WDT_MODULE && wdt_active) begin
					if (paddr == slot_addr(counter_array_pkg::COMPARE_LOW_BASE, i)) begin
						next_s.cmp_low[i] = wb;
					end
					if (paddr == slot_addr(counter_array_pkg::COMPARE_HIGH_BASE, i)) begin
						next_s.cmp_high[i] = s.count[15:8] + s.cmp_low[i];
					end
				end else begin
					if (paddr == slot_addr(counter_array_pkg::MODULE_MODE_BASE, i)) begin
						next_s.module_mode[i] = wb;
					end
					if (paddr == slot_addr(counter_array_pkg::COMPARE_LOW_BASE, i)) begin
						next_s.cmp_low[i] = wb;
						next_s.module_mode[i][counter_array_pkg::MM_ECOM_BIT] =
						    1'b0;
					end
					if (paddr == slot_addr(counter_array_pkg::COMPARE_HIGH_BASE, i)) begin
						next_s.cmp_high[i] = wb;
						next_s.module_mode[i][counter_array_pkg::MM_ECOM_BIT] =
						    1'b1;
					end
				end
			end
		end
		if (count_write) begin
			next_s.count = next_s.count;
		end

		// Hardware sets win over a clearing write in the same cycle.
		next_s.event_flag = next_s.event_flag | set_flags;
		if (full_ovf) begin
			next_s.ovf_flag = 1'b1;
		end
		next_s.irq = (next_s.ovf_flag & next_s.ovf_irq_enable);
		for (int i = 0; i < counter_array_pkg::NUM_MODULES; i++) begin
			if (next_s.event_flag[i] &
			    next_s.module_mode[i][counter_array_pkg::MM_IRQ_BIT]) begin
				next_s.irq = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.count <= counter_array_pkg::COUNT_RESET;
			s.wdt_enable <= counter_array_pkg::ARRAY_MODE_RESET[
			                    counter_array_pkg::AM_WATCHDOG_ENABLE_BIT];
			s.timebase <= counter_array_pkg::TB_DIV12;
			s.module_mode <= {counter_array_pkg::NUM_MODULES{
			                     counter_array_pkg::MODULE_MODE_RESET}};
			s.cmp_low <= {counter_array_pkg::NUM_MODULES{
			                 counter_array_pkg::COMPARE_RESET}};
			s.cmp_high <= {counter_array_pkg::NUM_MODULES{
			                  counter_array_pkg::COMPARE_RESET}};
		end else begin
			s <= next_s;
		end
	end

endmodule

`default_nettype wire

// file: rtl/counter_array_pkg.sv
/*
 * Constants shared by the counter array design: register byte offsets on
 * the APB bus, field positions, reset values, timebase codes and the
 * prescaler counts. Assumes a 32-bit APB bus with byte addresses.
 */
`default_nettype none

package counter_array_pkg;

	localparam int NUM_MODULES = 5;
	localparam int WDT_MODULE  = 4;

	// Byte offsets; module registers sit one word apart from their base.
	localparam logic [7:0] CONTROL_OFFSET      = 8'h00;
	localparam logic [7:0] ARRAY_MODE_OFFSET   = 8'h04;
	localparam logic [7:0] COUNT_LOW_OFFSET    = 8'h08;
	localparam logic [7:0] COUNT_HIGH_OFFSET   = 8'h0C;
	localparam logic [7:0] MODULE_MODE_BASE    = 8'h10;
	localparam logic [7:0] COMPARE_LOW_BASE    = 8'h30;
	localparam logic [7:0] COMPARE_HIGH_BASE   = 8'h50;
	localparam logic [7:0] MODULE_STRIDE       = 8'h04;

	// Reset values.
	localparam logic [7:0] CONTROL_RESET       = 8'h00;
	localparam logic [7:0] ARRAY_MODE_RESET    = 8'h40;
	localparam logic [7:0] MODULE_MODE_RESET   = 8'h00;
	localparam logic [7:0] COMPARE_RESET       = 8'h00;
	localparam logic [15:0] COUNT_RESET        = 16'h0000;

	// Control register fields.
	localparam int CTL_OVF_BIT  = 7;
	localparam int CTL_RUN_BIT  = 6;

	// Array mode register fields.
	localparam int AM_IDLE_BIT  = 7;
	localparam int AM_WATCHDOG_ENABLE_BIT  = 6;
	localparam int AM_WATCHDOG_LOCK_BIT = 5;
	localparam int AM_TB_LSB    = 1;
	localparam int AM_OVFIE_BIT = 0;

	// Module mode register fields.
	localparam int MM_WIDE_BIT  = 7;
	localparam int MM_ECOM_BIT  = 6;
	localparam int MM_CAPP_BIT  = 5;
	localparam int MM_CAPN_BIT  = 4;
	localparam int MM_MAT_BIT   = 3;
	localparam int MM_TOG_BIT   = 2;
	localparam int MM_PWM_BIT   = 1;
	localparam int MM_IRQ_BIT   = 0;

	// Timebase select codes.
	localparam logic [2:0] TB_DIV12  = 3'h0;
	localparam logic [2:0] TB_DIV4   = 3'h1;
	localparam logic [2:0] TB_TIMER0 = 3'h2;
	localparam logic [2:0] TB_EVENT  = 3'h3;
	localparam logic [2:0] TB_SYSCLK = 3'h4;
	localparam logic [2:0] TB_EXT8   = 3'h5;

	// Prescaler terminal counts.
	localparam logic [3:0] DIV12_LAST = 4'hB;
	localparam logic [1:0] DIV4_LAST  = 2'h3;
	localparam logic [2:0] EXT8_LAST  = 3'h7;

endpackage

`default_nettype wire

// file: sim/cpu_core_model.sv
/*
 * CPU side of the register bus: an APB master with byte register tasks.
 * Assumes an APB slave on pclk; tasks are entered just after a rising edge.
 */
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
	// Bus
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// No cycle limit here: a slave that never answers is ended
		// by the bench's own watchdog.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata[7:0];
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		xfer(1'b0, a, 8'h00, q);
	endtask

	// Disable first, then timebase with idle off, offset, enable, reload.
	task automatic wdt_setup(input logic [7:0] ofs);
		wr(8'h04, 8'h00);
		wr(8'h04, 8'h08);
		wr(8'h40, ofs);
		wr(8'h04, 8'h48);
		wr(8'h60, 8'h00);
	endtask
endmodule
`default_nettype wire

// file: sim/counter_array_props.sv
/*
 * Checker for the counter array, watching only its top-level ports.
 * Assumes one clock domain with an active-low asynchronous reset.
 */
`timescale 1ns/10ps
`default_nettype none
module counter_array_props (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Bus
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	// Outputs
	input  wire logic [4:0]  module_output_pin,
	input  wire logic        array_irq,
	input  wire logic        watchdog_reset
);
	logic       wr;
	logic       acc;
	logic       ok;
	logic       watchdog_enable;
	logic       lock;
	logic [7:0] mode [4];

	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign ok = paddr[1:0] == 2'h0 && (paddr < 8'h24
		|| (paddr >= 8'h30 && paddr < 8'h44)
		|| (paddr >= 8'h50 && paddr < 8'h64));

	// Shadow of the watchdog state and of modules 0 to 3.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_enable <= 1'b1;
			lock <= 1'b0;
			mode <= '{default: 8'h00};
		end else if (wr) begin
			if (paddr == 8'h04) begin
				watchdog_enable <= pwdata[6];
				lock <= lock | (pwdata[5] & ~watchdog_enable);
			end
			for (int i = 0; i < 4; i++) begin
				if (paddr == 8'h10 + 8'(4 * i))
					mode[i] <= pwdata[7:0];
				if (paddr == 8'h30 + 8'(4 * i))
					mode[i][6] <= 1'b0;
				if (paddr == 8'h50 + 8'(4 * i))
					mode[i][6] <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence force_wr_s;
		wr && paddr == 8'h00 && pwdata[4] && (watchdog_enable || lock);
	endsequence
	sequence pulse_s;
		watchdog_reset ##1 !watchdog_reset;
	endsequence

	pready_follow_a: assert property (psel |-> pready == penable)
		else $error("pready not equal to penable");
	bad_addr_a: assert property (acc && !ok
		|-> pslverr && (pwrite || prdata == 32'h00000000))
		else $error("unmapped access not refused");
	good_addr_a: assert property (acc && ok |-> !pslverr)
		else $error("mapped access refused");
	flag_hold_a: assert property ($fell(array_irq)
		|-> $past(wr) || $past(wr, 2))
		else $error("interrupt fell without a write");
	force_reset_a: assert property (force_wr_s |=> pulse_s)
		else $error("forced watchdog reset missing");
	reset_pulse_a: assert property (watchdog_reset |=> !watchdog_reset)
		else $error("watchdog reset longer than one cycle");
	reset_cause_a: assert property (watchdog_reset
		|-> $past(watchdog_enable || lock))
		else $error("watchdog reset while watchdog off");
	for (genvar g = 0; g < 4; g++) begin : gp
		idle_pin_a: assert property ($past(mode[g]) == 8'h00
			|-> $stable(module_output_pin[g]))
			else $error("pin moved in unused module");
	end
endmodule

bind counter_array_compare counter_array_props u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr),
	.module_output_pin(module_output_pin), .array_irq(array_irq),
	.watchdog_reset(watchdog_reset));
`default_nettype wire

// file: sim/test_counter_array_compare.sv
/*
 * Self-checking bench for the counter array: watchdog, compare modes, bus.
 * Assumes the CPU model in cpu_core_model and the bound checker.
 */
`timescale 1ns/10ps
`default_nettype none
module test_counter_array_compare;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        tmr = 1'b0;
	logic        evt = 1'b0;
	logic        ext = 1'b0;
	logic        idle = 1'b0;
	logic [4:0]  pin;
	logic        irq;
	logic        wdr;
	int          n_fail = 0;
	int          check_count = 0;
	int          n;
	int          ones;
	int          tog;
	logic [7:0]  q;
	logic [7:0]  h;
	logic [15:0] cv;
	logic [31:0] seed = 32'h9621;

	counter_array_compare dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer0_overflow(tmr), .count_event_pin(evt),
		.ext_clock_pin(ext), .cpu_idle(idle), .module_output_pin(pin),
		.array_irq(irq), .watchdog_reset(wdr));
	cpu_core_model u_cpu (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic int pwm_ones(input logic [7:0] v);
		return 2 * (256 - v);
	endfunction
	function automatic int half(input logic [7:0] v);
		return (v == 8'h00) ? 256 : v;
	endfunction

	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic do_reset;
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task automatic wait_wdt(output int c);
		c = 0;
		while (wdr !== 1'b1 && c < 4000) begin
			@(posedge pclk);
			c++;
		end
	endtask
	task automatic sample(input int i, input int cyc,
		output int o, output int t);
		logic p;
		o = 0;
		t = 0;
		p = pin[i];
		repeat (cyc) begin
			@(posedge pclk);
			o += (pin[i] === 1'b1);
			t += (pin[i] !== p);
			p = pin[i];
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		#1000000;
		n_fail++;
		print_verdict;
	end

	initial begin
		do_reset;
		u_cpu.rd(8'h04, q);
		chk("mode_reset", q, 8'h40);
		u_cpu.rd(8'h40, q);
		chk("offset_reset", q, 8'h00);
		u_cpu.wr(8'h0C, 8'h55);
		u_cpu.wr(8'h04, 8'h6A);
		u_cpu.rd(8'h08, q);
		u_cpu.rd(8'h0C, q);
		chk("count_locked", q, 8'h00);
		u_cpu.rd(8'h04, q);
		chk("mode_locked", q, 8'h40);
		u_cpu.rd(8'h00, q);
		chk("run_reads", q[6], 1'b0);
		wait_wdt(n);
		chk("wdt_default", n >= 3000 && n <= 3100, 1'b1);
		$display("test watchdog defaults done");
		do_reset;
		u_cpu.wr(8'h00, 8'h10);
		wait_wdt(n);
		chk("wdt_force", n <= 3, 1'b1);
		do_reset;
		u_cpu.wdt_setup(8'h02);
		wait_wdt(n);
		chk("wdt_reload", n >= 512 && n <= 800, 1'b1);
		$display("test watchdog reload done");
		do_reset;
		u_cpu.wr(8'h04, 8'h00);
		u_cpu.rd(8'h04, q);
		chk("wdt_off", q, 8'h00);
		u_cpu.wr(8'h04, 8'h08);
		u_cpu.rd(8'h04, q);
		chk("tb_set", q, 8'h08);
		u_cpu.wr(8'h70, 8'hFF);
		u_cpu.rd(8'h24, q);
		chk("unmapped", q, 8'h00);
		seed = xs(seed);
		cv = 16'h0100 + 16'(seed[7:0]);
		u_cpu.wr(8'h10, 8'h49);
		u_cpu.wr(8'h08, 8'h00);
		u_cpu.wr(8'h0C, 8'h00);
		u_cpu.wr(8'h30, cv[7:0]);
		u_cpu.rd(8'h10, q);
		chk("ecom_clear", q, 8'h09);
		u_cpu.wr(8'h50, cv[15:8]);
		u_cpu.rd(8'h10, q);
		chk("ecom_set", q, 8'h49);
		u_cpu.wr(8'h00, 8'h40);
		n = 0;
		while (irq !== 1'b1 && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		chk("match_time", n >= cv - 4 && n <= cv + 4, 1'b1);
		repeat (300) @(posedge pclk);
		chk("flag_held", irq, 1'b1);
		u_cpu.wr(8'h00, 8'h40);
		chk("flag_clear", irq, 1'b0);
		u_cpu.wr(8'h14, 8'h4C);
		u_cpu.wr(8'h34, 8'h00);
		u_cpu.wr(8'h54, 8'h09);
		sample(1, 3000, ones, tog);
		chk("toggle", tog, 1);
		$display("test timer and toggle done");
		for (int k = 0; k < 3; k++) begin
			seed = xs(seed);
			h = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : seed[7:0];
			u_cpu.wr(8'h18, 8'h42);
			u_cpu.wr(8'h38, h);
			u_cpu.wr(8'h58, h);
			repeat (300) @(posedge pclk);
			sample(2, 512, ones, tog);
			chk("pwm8_duty", ones, pwm_ones(h));
			h = (k == 0) ? 8'h10 : (k == 1) ? 8'h00 : seed[15:8] | 8'h01;
			u_cpu.wr(8'h1C, 8'h46);
			u_cpu.wr(8'h3C, 8'h00);
			u_cpu.wr(8'h5C, h);
			repeat (600) @(posedge pclk);
			sample(3, 8 * half(h), ones, tog);
			chk("freq_toggles", tog, 8);
		end
		u_cpu.wr(8'h38, 8'h00);
		repeat (10) @(posedge pclk);
		sample(2, 512, ones, tog);
		chk("pwm8_off", ones, 0);
		$display("test pulse and frequency done");
		// Wide pulse on module 0 with match interrupts on, so that the
		// match is seen on the interrupt before the later duty change.
		u_cpu.wr(8'h10, 8'hCB);
		u_cpu.wr(8'h30, 8'h80);
		u_cpu.wr(8'h50, 8'hFF);
		u_cpu.wr(8'h08, 8'h00);
		u_cpu.wr(8'h0C, 8'hFF);
		sample(0, 300, ones, tog);
		chk("pwm16_duty", ones, 128);
		chk("pwm16_edges", tog, 2);
		chk("pwm16_irq", irq, 1'b1);
		u_cpu.wr(8'h00, 8'h40);
		u_cpu.wr(8'h30, 8'h00);
		u_cpu.wr(8'h50, 8'h00);
		u_cpu.wr(8'h0C, 8'hFF);
		repeat (300) @(posedge pclk);
		sample(0, 256, ones, tog);
		chk("pwm16_full", ones, 256);
		// Falling event edges, then timer 0 pulses, as timebase.
		u_cpu.wr(8'h04, 8'h06);
		u_cpu.wr(8'h08, 8'h00);
		repeat (5) begin
			evt <= 1'b1;
			repeat (4) @(posedge pclk);
			evt <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		u_cpu.rd(8'h08, q);
		chk("event_ticks", q, 8'h05);
		u_cpu.wr(8'h04, 8'h04);
		repeat (3) begin
			tmr <= 1'b1;
			@(posedge pclk);
			tmr <= 1'b0;
			repeat (2) @(posedge pclk);
		end
		u_cpu.rd(8'h08, q);
		chk("timer_ticks", q, 8'h08);
		$display("test wide pulse and timebase done");
		print_verdict;
	end
endmodule
`default_nettype wire
